// File: core/cx_pkg.sv
// constants and types for the instruction execution subset
package cx_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int PC_W = 13;
	localparam int STACK_DEPTH = 8;
	localparam int STACK_PTR_W = 3;
	localparam int WDT_W = 8;
	localparam int PRESCALE_W = 8;
	localparam logic [7:0] WORK_RESET = 8'h00;
	localparam logic [7:0] WDT_CLEAR = 8'h00;
	localparam logic [7:0] PRESCALE_CLEAR = 8'h00;
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [2:0] RETURN_CYCLES = 3'h2;
	localparam logic DEST_WORK = 1'b0;
	localparam logic DEST_FILE = 1'b1;
	localparam int NIB_LO = 0;
	localparam int NIB_HI = 4;
	localparam int NIB_W = 4;

	typedef enum logic [2:0] {
		CX_OP_NONE = 3'b000,
		CX_OP_RETURN = 3'b001,
		CX_OP_SLEEP = 3'b010,
		CX_OP_LITERAL_MINUS_WORK = 3'b011,
		CX_OP_XOR_LITERAL = 3'b100,
		CX_OP_FILE_MINUS_WORK = 3'b101,
		CX_OP_NIBBLE_EXCHANGE = 3'b110,
		CX_OP_XOR_FILE = 3'b111
	} cx_op_t;

	typedef enum logic [1:0] {
		CX_ST_RUN = 2'b00,
		CX_ST_RETURN = 2'b01,
		CX_ST_SLEEP = 2'b10
	} cx_state_t;
endpackage

// File: core/cx_stack.sv
// return address stack, eight entries, registered top value
module cx_stack #(
	parameter int DEPTH = cx_pkg::STACK_DEPTH,
	parameter int WIDTH = cx_pkg::PC_W
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_value,
	input wire logic pop,
	output logic [WIDTH-1:0] stack_top_value
);
	logic [cx_pkg::STACK_PTR_W-1:0] ptr;
	logic [cx_pkg::STACK_PTR_W-1:0] next_ptr;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] next_top;

	// circular like the real stack: overflow wraps over the oldest entry
	always_comb begin
		next_ptr = ptr;
		next_top = stack_top_value;
		if (push) begin
			next_ptr = ptr + 3'h1;
			next_top = push_value;
		end else if (pop) begin
			next_ptr = ptr - 3'h1;
			next_top = mem[ptr - 3'h1];
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ptr <= '0;
			stack_top_value <= '0;
		end else if (clk_en) begin
			ptr <= next_ptr;
			stack_top_value <= next_top;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (clk_en && push) begin
			mem[ptr] <= stack_top_value;
		end
	end
endmodule

// File: core/cx_exec.sv
// execution of return, sleep, subtract, xor and nibble swap instructions
// Behaviour
// RULE1: return pops stack into pc, two cycles
// RULE2: sleep clears watchdog, prescaler; sets time-out, clears power-down
// RULE3: after sleep, halt in low-power state
// RULE4: literal minus work into work, flags c dc z
// RULE5: literal xor work into work, z only
// RULE6: file minus work, seven bit address, c dc z
// RULE7: destination bit zero work, one file
// RULE8: nibble swap of file, flags unchanged
// RULE9: file xor work into destination, z only
// RULE10: z on zero; c, dc mean no borrow
module cx_exec (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic instr_valid,
	input wire cx_pkg::cx_op_t instr_op,
	input wire logic [7:0] instr_literal,
	input wire logic [6:0] instr_file_addr,
	input wire logic instr_dest,
	input wire logic [7:0] file_rdata,
	input wire logic call_push,
	input wire logic [12:0] call_addr,
	input wire logic wdt_tick,
	input wire logic wake_event,
	output logic instr_ready,
	output logic [6:0] file_addr,
	output logic file_we,
	output logic [7:0] file_wdata,
	output logic [7:0] work_reg,
	output logic carry_flag,
	output logic digit_carry_flag,
	output logic zero_flag,
	output logic time_out_flag,
	output logic power_down_flag,
	output logic [7:0] watchdog_counter,
	output logic [7:0] wdt_prescale,
	output logic [12:0] pc,
	output logic osc_halt
);
	cx_pkg::cx_state_t state, next_state;
	logic [7:0] next_work;
	logic next_c, next_dc, next_z, next_to, next_pd;
	logic [7:0] next_wdt, next_pre;
	logic [12:0] next_pc;
	logic [6:0] next_faddr;
	logic next_fwe;
	logic [7:0] next_fwdata;
	logic next_halt;
	logic pop;
	logic [12:0] stack_top_value;
	logic [7:0] src_a, result;
	logic [8:0] diff;
	logic [4:0] diff_lo;
	logic take;

	assign instr_ready = (state == cx_pkg::CX_ST_RUN);
	assign take = instr_valid && instr_ready;
	assign pop = take && (instr_op == cx_pkg::CX_OP_RETURN); // RULE1

	cx_stack u_stack (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.push(call_push && !pop),
		.push_value(call_addr),
		.pop(pop),
		.stack_top_value(stack_top_value)
	);

	// ==========================================================
	// arithmetic
	always_comb begin
		if (instr_op == cx_pkg::CX_OP_LITERAL_MINUS_WORK || instr_op == cx_pkg::CX_OP_XOR_LITERAL) begin
			src_a = instr_literal;
		end else begin
			src_a = file_rdata;
		end
		diff = {1'b0, src_a} + {1'b0, ~work_reg} + 9'h001; // RULE4 RULE6
		diff_lo = {1'b0, src_a[3:0]} + {1'b0, ~work_reg[3:0]} + 5'h01; // RULE10
		case (instr_op)
			cx_pkg::CX_OP_XOR_LITERAL,
			cx_pkg::CX_OP_XOR_FILE: result = src_a ^ work_reg; // RULE5 RULE9
			cx_pkg::CX_OP_NIBBLE_EXCHANGE: result = {src_a[3:0], src_a[7:4]}; // RULE8
			default: result = diff[7:0];
		endcase
	end

	// ==========================================================
	// next state
	always_comb begin
		next_state = state;
		next_work = work_reg;
		next_c = carry_flag;
		next_dc = digit_carry_flag;
		next_z = zero_flag;
		next_to = time_out_flag;
		next_pd = power_down_flag;
		next_wdt = watchdog_counter;
		next_pre = wdt_prescale;
		next_pc = pc;
		next_faddr = file_addr;
		next_fwe = 1'b0;
		next_fwdata = file_wdata;
		next_halt = osc_halt;
		if (wdt_tick && !osc_halt) begin
			next_pre = wdt_prescale + 8'h01;
			if (wdt_prescale == 8'hff) begin
				next_wdt = watchdog_counter + 8'h01;
			end
		end
		case (state)
			cx_pkg::CX_ST_RUN: begin
				if (take) begin
					next_pc = pc + 13'h0001;
					case (instr_op)
						cx_pkg::CX_OP_RETURN: begin
							next_pc = stack_top_value; // RULE1
							next_state = cx_pkg::CX_ST_RETURN;
						end
						cx_pkg::CX_OP_SLEEP: begin
							next_wdt = cx_pkg::WDT_CLEAR; // RULE2
							next_pre = cx_pkg::PRESCALE_CLEAR; // RULE2
							next_to = 1'b1; // RULE2
							next_pd = 1'b0; // RULE2
							next_halt = 1'b1; // RULE3
							next_state = cx_pkg::CX_ST_SLEEP; // RULE3
						end
						cx_pkg::CX_OP_LITERAL_MINUS_WORK,
						cx_pkg::CX_OP_XOR_LITERAL: begin
							next_work = result; // RULE4 RULE5
							next_z = (result == 8'h00); // RULE10
							if (instr_op == cx_pkg::CX_OP_LITERAL_MINUS_WORK) begin
								next_c = diff[8]; // RULE10
								next_dc = diff_lo[4]; // RULE10
							end
						end
						cx_pkg::CX_OP_FILE_MINUS_WORK,
						cx_pkg::CX_OP_XOR_FILE,
						cx_pkg::CX_OP_NIBBLE_EXCHANGE: begin
							if (instr_dest == cx_pkg::DEST_FILE) begin // RULE7
								next_fwe = 1'b1;
								next_faddr = instr_file_addr; // RULE6
								next_fwdata = result;
							end else begin
								next_work = result;
							end
							if (instr_op != cx_pkg::CX_OP_NIBBLE_EXCHANGE) begin
								next_z = (result == 8'h00); // RULE9 RULE10
							end
							if (instr_op == cx_pkg::CX_OP_FILE_MINUS_WORK) begin
								next_c = diff[8]; // RULE6
								next_dc = diff_lo[4]; // RULE6
							end
						end
						default: begin
						end
					endcase
				end
			end
			cx_pkg::CX_ST_RETURN: next_state = cx_pkg::CX_ST_RUN; // RULE1
			cx_pkg::CX_ST_SLEEP: begin
				if (wake_event) begin
					next_halt = 1'b0;
					next_state = cx_pkg::CX_ST_RUN;
				end
			end
			default: next_state = cx_pkg::CX_ST_RUN;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= cx_pkg::CX_ST_RUN;
			work_reg <= cx_pkg::WORK_RESET;
			carry_flag <= 1'b0;
			digit_carry_flag <= 1'b0;
			zero_flag <= 1'b0;
			time_out_flag <= 1'b1;
			power_down_flag <= 1'b1;
			watchdog_counter <= cx_pkg::WDT_CLEAR;
			wdt_prescale <= cx_pkg::PRESCALE_CLEAR;
			pc <= cx_pkg::PC_RESET;
			file_addr <= 7'h00;
			file_we <= 1'b0;
			file_wdata <= 8'h00;
			osc_halt <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			work_reg <= next_work;
			carry_flag <= next_c;
			digit_carry_flag <= next_dc;
			zero_flag <= next_z;
			time_out_flag <= next_to;
			power_down_flag <= next_pd;
			watchdog_counter <= next_wdt;
			wdt_prescale <= next_pre;
			pc <= next_pc;
			file_addr <= next_faddr;
			file_we <= next_fwe;
			file_wdata <= next_fwdata;
			osc_halt <= next_halt;
		end
	end

	// ==========================================================
	// assertions
	a_return_two_cycles: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && pop |=> !instr_ready) // RULE1
		else $error("return did not take two cycles");
	a_return_flags_kept: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && pop |=> $stable({carry_flag, digit_carry_flag, zero_flag})) // RULE1
		else $error("return changed flags");
	a_return_loads_pc: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && pop |=> pc == $past(stack_top_value)) // RULE1
		else $error("return pc not from stack");
	a_sleep_status: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && take && instr_op == cx_pkg::CX_OP_SLEEP |=>
		time_out_flag && !power_down_flag && watchdog_counter == 8'h00 && wdt_prescale == 8'h00) // RULE2
		else $error("sleep status wrong");
	a_sleep_halt: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && take && instr_op == cx_pkg::CX_OP_SLEEP |=> osc_halt && !instr_ready) // RULE3
		else $error("sleep did not halt");
	a_sub_literal: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && take && instr_op == cx_pkg::CX_OP_LITERAL_MINUS_WORK |=>
		work_reg == 8'($past(instr_literal) - $past(work_reg))
		&& carry_flag == ($past(instr_literal) >= $past(work_reg))) // RULE4
		else $error("literal subtract wrong");
	a_xor_literal: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && take && instr_op == cx_pkg::CX_OP_XOR_LITERAL |=>
		work_reg == ($past(instr_literal) ^ $past(work_reg)) && $stable(carry_flag)) // RULE5
		else $error("literal xor wrong");
	a_sub_file_dest: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && take && instr_op == cx_pkg::CX_OP_FILE_MINUS_WORK && instr_dest |=>
		file_we && file_addr == $past(instr_file_addr)
		&& file_wdata == 8'($past(file_rdata) - $past(work_reg))) // RULE6
		else $error("file subtract wrong");
	a_dest_work: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && take && instr_op == cx_pkg::CX_OP_XOR_FILE && !instr_dest |=>
		!file_we && work_reg == ($past(file_rdata) ^ $past(work_reg))) // RULE7 RULE9
		else $error("work destination wrong");
	a_swap_nibbles: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && take && instr_op == cx_pkg::CX_OP_NIBBLE_EXCHANGE && !instr_dest |=>
		work_reg == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && $stable(zero_flag)) // RULE8
		else $error("nibble swap wrong");
	a_zero_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && take && instr_op == cx_pkg::CX_OP_XOR_LITERAL |=> zero_flag == (work_reg == 8'h00)) // RULE10
		else $error("zero flag wrong");
	c_return: cover property (@(posedge sys_clk) disable iff (!reset_n) clk_en && pop);
	c_sleep_wake: cover property (@(posedge sys_clk) disable iff (!reset_n) osc_halt ##[1:20] !osc_halt);
	c_borrow: cover property (@(posedge sys_clk) disable iff (!reset_n)
		take && instr_op == cx_pkg::CX_OP_FILE_MINUS_WORK ##1 !carry_flag);
endmodule

// File: sim/tb_top.sv
// self-checking testbench for the instruction execution subset
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, reset_n, clk_en, instr_valid, instr_dest, call_push, wdt_tick, wake_event;
	cx_pkg::cx_op_t instr_op;
	logic [7:0] instr_literal, file_rdata, work_reg, file_wdata, watchdog_counter, wdt_prescale;
	logic [6:0] instr_file_addr, file_addr;
	logic [12:0] call_addr, pc;
	logic instr_ready, file_we, carry_flag, digit_carry_flag, zero_flag;
	logic time_out_flag, power_down_flag, osc_halt;
	logic [7:0] fmem [128];
	logic [12:0] stk [8];
	logic [2:0] sp;
	logic [7:0] ew;
	logic ec, edc, ez;
	int n_mismatch, total_checks, cycles, seed, r;
	cx_pkg::cx_op_t ops [5] = '{cx_pkg::CX_OP_LITERAL_MINUS_WORK, cx_pkg::CX_OP_XOR_LITERAL,
		cx_pkg::CX_OP_FILE_MINUS_WORK, cx_pkg::CX_OP_NIBBLE_EXCHANGE, cx_pkg::CX_OP_XOR_FILE};

	cx_exec dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
		.instr_valid(instr_valid), .instr_op(instr_op), .instr_literal(instr_literal),
		.instr_file_addr(instr_file_addr), .instr_dest(instr_dest), .file_rdata(file_rdata),
		.call_push(call_push), .call_addr(call_addr), .wdt_tick(wdt_tick),
		.wake_event(wake_event), .instr_ready(instr_ready), .file_addr(file_addr),
		.file_we(file_we), .file_wdata(file_wdata), .work_reg(work_reg),
		.carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
		.time_out_flag(time_out_flag), .power_down_flag(power_down_flag),
		.watchdog_counter(watchdog_counter), .wdt_prescale(wdt_prescale), .pc(pc),
		.osc_halt(osc_halt));

	// ==========================================
	// file register memory seen by the core
	assign file_rdata = fmem[instr_file_addr];
	always @(posedge sys_clk) begin
		if (file_we === 1'b1)
			fmem[file_addr] <= file_wdata;
	end

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	// ==========================================
	// checking helpers
	task automatic report_and_stop();
		if (n_mismatch == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// borrow-style subtract: {no borrow, no nibble borrow, difference}
	function automatic logic [9:0] subf(input logic [7:0] a, input logic [7:0] b);
		return {a >= b, a[3:0] >= b[3:0], 8'(a - b)};
	endfunction

	task automatic check_flags();
		check("carry_flag", carry_flag, ec);
		check("digit_carry_flag", digit_carry_flag, edc);
		check("zero_flag", zero_flag, ez);
	endtask

	// ==========================================
	// one arithmetic or logic instruction, with expectation
	task automatic run_op(input cx_pkg::cx_op_t op, input logic [7:0] k, input logic [6:0] f,
		input logic d);
		logic [9:0] s;
		logic [7:0] res;
		logic to_file;
		@(posedge sys_clk);
		instr_valid <= 1'b1;
		instr_op <= op;
		instr_literal <= k;
		instr_file_addr <= f;
		instr_dest <= d;
		#1;
		to_file = 1'b0;
		case (op)
			cx_pkg::CX_OP_LITERAL_MINUS_WORK, cx_pkg::CX_OP_FILE_MINUS_WORK: begin
				s = subf((op == cx_pkg::CX_OP_FILE_MINUS_WORK) ? fmem[f] : k, ew);
				{ec, edc, res} = s;
				ez = (res == 8'h00);
			end
			cx_pkg::CX_OP_NIBBLE_EXCHANGE: res = {fmem[f][3:0], fmem[f][7:4]};
			cx_pkg::CX_OP_XOR_LITERAL: res = ew ^ k;
			default: res = ew ^ fmem[f];
		endcase
		if (op == cx_pkg::CX_OP_XOR_LITERAL || op == cx_pkg::CX_OP_XOR_FILE)
			ez = (res == 8'h00);
		if (op == cx_pkg::CX_OP_LITERAL_MINUS_WORK || op == cx_pkg::CX_OP_XOR_LITERAL)
			ew = res;
		else if (d == cx_pkg::DEST_FILE)
			to_file = 1'b1;
		else
			ew = res;
		@(posedge sys_clk);
		instr_valid <= 1'b0;
		#1;
		check("work_reg", work_reg, ew);
		check_flags();
		check("file_we", file_we, to_file);
		if (to_file) begin
			check("file_wdata", file_wdata, res);
			check("file_addr", file_addr, f);
		end
	endtask

	task automatic push_call(input logic [12:0] a);
		@(posedge sys_clk);
		call_push <= 1'b1;
		call_addr <= a;
		@(posedge sys_clk);
		call_push <= 1'b0;
		stk[sp] = a;
		sp = sp + 3'h1;
	endtask

	task automatic do_return();
		@(posedge sys_clk);
		instr_valid <= 1'b1;
		instr_op <= cx_pkg::CX_OP_RETURN;
		sp = sp - 3'h1;
		@(posedge sys_clk);
		instr_valid <= 1'b0;
		#1;
		check("pc", pc, stk[sp]);
		check("instr_ready", instr_ready, 1'b0);
		check_flags();
		@(posedge sys_clk);
		#1;
		check("instr_ready", instr_ready, 1'b1);
	endtask

	// ==========================================
	// main sequence
	initial begin
		seed = 32'h15e2;
		{reset_n, clk_en, instr_valid, instr_dest, call_push, wdt_tick, wake_event} = 7'h00;
		instr_op = cx_pkg::CX_OP_NONE;
		instr_literal = 8'h00;
		instr_file_addr = 7'h00;
		call_addr = 13'h0000;
		sp = 3'h0;
		{ew, ec, edc, ez} = 11'h000;
		for (int i = 0; i < 128; i++) begin
			r = $random(seed);
			fmem[i] = r[7:0];
		end
		repeat (3) @(posedge sys_clk);
		#1;
		check("time_out_flag", time_out_flag, 1'b1);
		check("power_down_flag", power_down_flag, 1'b1);
		check("work_reg", work_reg, 8'h00);
		check("instr_ready", instr_ready, 1'b1);
		@(posedge sys_clk);
		reset_n <= 1'b1;
		clk_en <= 1'b1;
		run_op(cx_pkg::CX_OP_LITERAL_MINUS_WORK, 8'h00, 7'h00, 1'b0);
		run_op(cx_pkg::CX_OP_XOR_LITERAL, 8'h3c, 7'h00, 1'b0);
		run_op(cx_pkg::CX_OP_LITERAL_MINUS_WORK, 8'h3c, 7'h00, 1'b0);
		run_op(cx_pkg::CX_OP_XOR_LITERAL, 8'h81, 7'h00, 1'b0);
		run_op(cx_pkg::CX_OP_LITERAL_MINUS_WORK, 8'h10, 7'h00, 1'b0);
		run_op(cx_pkg::CX_OP_FILE_MINUS_WORK, 8'h00, 7'h7f, 1'b1);
		run_op(cx_pkg::CX_OP_FILE_MINUS_WORK, 8'h00, 7'h7f, 1'b0);
		run_op(cx_pkg::CX_OP_NIBBLE_EXCHANGE, 8'h00, 7'h00, 1'b1);
		run_op(cx_pkg::CX_OP_NIBBLE_EXCHANGE, 8'h00, 7'h00, 1'b0);
		run_op(cx_pkg::CX_OP_XOR_FILE, 8'h00, 7'h40, 1'b1);
		run_op(cx_pkg::CX_OP_XOR_FILE, 8'h00, 7'h40, 1'b0);
		for (int i = 0; i < 150; i++) begin
			r = $random(seed);
			run_op(ops[r[10:8] % 5], r[7:0], r[17:11], r[18]);
		end
		push_call(13'h1abc);
		push_call(13'h0001);
		push_call(13'h1fff);
		do_return();
		do_return();
		push_call(13'h0a55);
		do_return();
		do_return();
		// 260 ticks: one prescaler wrap, so the clear below has work to do
		@(posedge sys_clk);
		wdt_tick <= 1'b1;
		repeat (260) @(posedge sys_clk);
		#1;
		check("watchdog_counter", watchdog_counter, 8'h01);
		check("wdt_prescale", wdt_prescale, 8'h04);
		// tick still high at the sleep edge: the clear must win
		@(posedge sys_clk);
		instr_valid <= 1'b1;
		instr_op <= cx_pkg::CX_OP_SLEEP;
		@(posedge sys_clk);
		instr_valid <= 1'b0;
		wdt_tick <= 1'b0;
		#1;
		check("watchdog_counter", watchdog_counter, 8'h00);
		check("wdt_prescale", wdt_prescale, 8'h00);
		check("time_out_flag", time_out_flag, 1'b1);
		check("power_down_flag", power_down_flag, 1'b0);
		check("osc_halt", osc_halt, 1'b1);
		// instruction offered while halted must be ignored
		@(posedge sys_clk);
		instr_valid <= 1'b1;
		instr_op <= cx_pkg::CX_OP_XOR_LITERAL;
		instr_literal <= 8'hff;
		repeat (3) @(posedge sys_clk);
		instr_valid <= 1'b0;
		wake_event <= 1'b1;
		#1;
		check("work_reg", work_reg, ew);
		check("osc_halt", osc_halt, 1'b1);
		@(posedge sys_clk);
		wake_event <= 1'b0;
		#1;
		check("osc_halt", osc_halt, 1'b0);
		check("instr_ready", instr_ready, 1'b1);
		// frozen core takes nothing
		@(posedge sys_clk);
		clk_en <= 1'b0;
		instr_valid <= 1'b1;
		repeat (2) @(posedge sys_clk);
		clk_en <= 1'b1;
		instr_valid <= 1'b0;
		#1;
		check("work_reg", work_reg, ew);
		run_op(cx_pkg::CX_OP_XOR_LITERAL, 8'h5a, 7'h00, 1'b0);
		report_and_stop();
	end
endmodule
